// ==== shared/damp_pkg.sv ====
// Constants for the drop alarm and multiframe provisioning block
package damp_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam int ADDR_W = 10;
   localparam logic [ADDR_W-1:0] CTRL_OFFSET = 10'h013;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int BIT_PTR_AIS = 7;
   localparam int BIT_V1_SEL = 6;
   localparam int BIT_V1_REF = 5;
   localparam int BIT_RDI_AUTO = 4;
   localparam int BIT_NPI_ZERO = 3;
   localparam int BIT_IND_DELAY = 2;
   localparam int BIT_UNEQ = 1;
   localparam int BIT_OBIT_ZERO = 0;
   // ----------------------------------------
   // Multiframe detection, NPI fill and O-bit port sizing
   // ----------------------------------------
   localparam logic [1:0] H4_V1_PHASE = 2'h0;
   localparam logic [7:0] NPI_FILL = 8'h00;
   localparam int PORTS = 4;
   localparam int OBIT_W = 8;
endpackage

// ==== shared/damp_cfg_if.sv ====
// Provisioning byte carried from the register to its users
`timescale 1ns/10ps
interface damp_cfg_if;
   logic [7:0] ctrl;
   modport owner (output ctrl);
   modport user (input ctrl);
endinterface

// ==== design/damp_ctrl_reg.sv ====
// Provisioning register with microprocessor port read-back
`timescale 1ns/10ps
module damp_ctrl_reg (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [damp_pkg::ADDR_W-1:0] up_addr_i,
   input wire logic [7:0] up_wdata_i,
   input wire logic up_wr_i,
   input wire logic up_rd_i,
   output logic [7:0] up_rdata_o,
   damp_cfg_if.owner cfg
);
   logic [7:0] ctrl;
   logic [7:0] next_ctrl;
   logic [7:0] next_rdata;

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   function automatic logic hit(input logic [damp_pkg::ADDR_W-1:0] a);
      hit = (a == damp_pkg::CTRL_OFFSET);
   endfunction

   always_comb begin
      next_ctrl = ctrl;
      next_rdata = up_rdata_o;
      if (up_wr_i && hit(up_addr_i)) begin
         next_ctrl = up_wdata_i;
      end
      if (up_rd_i && hit(up_addr_i)) begin
         next_rdata = ctrl;
      end else if (up_rd_i) begin
         next_rdata = damp_pkg::READ_UNMAPPED;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl <= damp_pkg::CTRL_RESET;
         up_rdata_o <= damp_pkg::READ_UNMAPPED;
      end else begin
         ctrl <= next_ctrl;
         up_rdata_o <= next_rdata;
      end
   end

   // Effective at once, no commit strobe
   assign cfg.ctrl = ctrl;

   a_write_takes_effect: assert property (@(posedge clock_i) disable iff (rst_i)
      up_wr_i && hit(up_addr_i) |=> cfg.ctrl == $past(up_wdata_i))
      else $error("written value not held");
endmodule // damp_ctrl_reg

// ==== design/damp_obit_force.sv ====
// O-bit channel and spare K4 bits per port, optionally forced to zero
`timescale 1ns/10ps
module damp_obit_force #(
   parameter int PORTS = damp_pkg::PORTS,
   parameter int OBIT_W = damp_pkg::OBIT_W
) (
   input wire logic clock_i,
   input wire logic rst_i,
   damp_cfg_if.user cfg,
   input wire logic [PORTS*OBIT_W-1:0] obit_sw_i,
   output logic [PORTS*OBIT_W-1:0] obit_tx_o
);
   logic [PORTS*OBIT_W-1:0] next_obit;

   // ----------------------------------------
   // Per-port selection
   // ----------------------------------------
   for (genvar p = 0; p < PORTS; p++) begin : g_port
      always_comb begin
         if (cfg.ctrl[damp_pkg::BIT_OBIT_ZERO]) begin
            next_obit[p*OBIT_W +: OBIT_W] = '0;
         end else begin
            next_obit[p*OBIT_W +: OBIT_W] = obit_sw_i[p*OBIT_W +: OBIT_W];
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         obit_tx_o <= '0;
      end else begin
         obit_tx_o <= next_obit;
      end
   end

   a_obit_zeroed: assert property (@(posedge clock_i) disable iff (rst_i)
      cfg.ctrl[damp_pkg::BIT_OBIT_ZERO] |=> obit_tx_o == '0)
      else $error("O-bit not forced to zero");
   a_obit_passed: assert property (@(posedge clock_i) disable iff (rst_i)
      !cfg.ctrl[damp_pkg::BIT_OBIT_ZERO] |=> obit_tx_o == $past(obit_sw_i))
      else $error("O-bit software value not sent");
endmodule // damp_obit_force

// ==== design/damp_top.sv ====
// Drop alarm consequents, V1 reference selection and drop bus options
//
// Overview of operation
// - With the pointer AIS enable set, AIS in pointer or E1 bytes on either drop bus forces line AIS and, when enabled, RDI.
// - With V1 source select clear, drop multiframe timing comes from H4 and the drop composite V1 pulses are ignored.
// - With V1 source select set, drop timing follows the A and B composite V1 pulses and the H4 detector is off.
// - Select 0, reference 0: drop uses the H4 detector, add uses the add bus composite V1 pulse.
// - Select 0, reference 1: drop and add both use the drop H4 detector pulse.
// - Select 1, reference 0: drop uses the drop composite V1, add uses the add composite V1.
// - Select 1, reference 1: drop uses the A and B composite V1, add uses the drop A composite V1 pulse.
// - With remote defect auto enable set, drop alarms raise RDI in the add direction, alongside the per-channel RDI control.
// - With NPI zero force set, unused bytes after the NPI column are driven as zeros, else left undriven.
// - With the indication delay set, the A and B drop indications are delayed by one more clock.
// - With O-bit zero force clear, software O-bit and spare K4 values are sent on all ports.
// - With O-bit zero force set, the O-bit and spare K4 bits are sent as zeros on all ports.
`timescale 1ns/10ps
module damp_top #(
   parameter int PORTS = damp_pkg::PORTS,
   parameter int OBIT_W = damp_pkg::OBIT_W
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [damp_pkg::ADDR_W-1:0] up_addr_i,
   input wire logic [7:0] up_wdata_i,
   input wire logic up_wr_i,
   input wire logic up_rd_i,
   output logic [7:0] up_rdata_o,
   input wire logic ptr_ais_a_i,
   input wire logic ptr_ais_b_i,
   input wire logic e1_ais_a_i,
   input wire logic e1_ais_b_i,
   input wire logic unequipped_a_i,
   input wire logic unequipped_b_i,
   input wire logic [PORTS-1:0] channel_rdi_control_i,
   output logic rx_line_ais_o,
   output logic [PORTS-1:0] tx_rdi_o,
   output logic tandem_odi_alarm_o,
   output logic tandem_rdi_alarm_o,
   input wire logic composite_frame_sync_a_i,
   input wire logic composite_frame_sync_b_i,
   input wire logic composite_frame_sync_add_i,
   input wire logic h4_valid_i,
   input wire logic [7:0] h4_byte_i,
   output logic drop_v1_a_o,
   output logic drop_v1_b_o,
   output logic add_v1_o,
   input wire logic drop_indication_a_i,
   input wire logic drop_indication_b_i,
   output logic drop_indication_a_o,
   output logic drop_indication_b_o,
   input wire logic npi_enable_i,
   input wire logic npi_unused_slot_i,
   output logic [7:0] npi_data_o,
   output logic npi_oe_o,
   input wire logic [PORTS*OBIT_W-1:0] obit_sw_i,
   output logic [PORTS*OBIT_W-1:0] obit_tx_o
);
   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   if (PORTS < 1 || OBIT_W < 1) begin : g_bad_param
      $error("PORTS and OBIT_W must be at least one");
   end

   // ----------------------------------------
   // Provisioning register
   // ----------------------------------------
   damp_cfg_if cfg ();

   damp_ctrl_reg u_reg (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .up_addr_i(up_addr_i),
      .up_wdata_i(up_wdata_i),
      .up_wr_i(up_wr_i),
      .up_rd_i(up_rd_i),
      .up_rdata_o(up_rdata_o),
      .cfg(cfg.owner)
   );

   damp_obit_force #(.PORTS(PORTS), .OBIT_W(OBIT_W)) u_obit (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .cfg(cfg.user),
      .obit_sw_i(obit_sw_i),
      .obit_tx_o(obit_tx_o)
   );

   logic ais_en;
   logic v1_sel;
   logic v1_ref;
   logic rdi_auto;
   logic npi_zero;
   logic ind_delay;
   logic uneq_en;
   assign ais_en = cfg.ctrl[damp_pkg::BIT_PTR_AIS];
   assign v1_sel = cfg.ctrl[damp_pkg::BIT_V1_SEL];
   assign v1_ref = cfg.ctrl[damp_pkg::BIT_V1_REF];
   assign rdi_auto = cfg.ctrl[damp_pkg::BIT_RDI_AUTO];
   assign npi_zero = cfg.ctrl[damp_pkg::BIT_NPI_ZERO];
   assign ind_delay = cfg.ctrl[damp_pkg::BIT_IND_DELAY];
   assign uneq_en = cfg.ctrl[damp_pkg::BIT_UNEQ];

   // ----------------------------------------
   // Alarm consequents
   // ----------------------------------------
   logic ais_cons;
   logic uneq_cons;
   logic next_line_ais;
   logic [PORTS-1:0] next_rdi;
   logic next_tc;

   always_comb begin
      ais_cons = ais_en && (ptr_ais_a_i || ptr_ais_b_i ||
         e1_ais_a_i || e1_ais_b_i);
      uneq_cons = uneq_en && (unequipped_a_i || unequipped_b_i);
      next_line_ais = ais_cons || uneq_cons;
      next_tc = uneq_cons;
      // Per-channel control always asserts RDI on its own port
      next_rdi = channel_rdi_control_i;
      if ((rdi_auto && ais_cons) || uneq_cons) begin
         next_rdi = {PORTS{1'b1}};
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rx_line_ais_o <= 1'b0;
         tx_rdi_o <= '0;
         tandem_odi_alarm_o <= 1'b0;
         tandem_rdi_alarm_o <= 1'b0;
      end else begin
         rx_line_ais_o <= next_line_ais;
         tx_rdi_o <= next_rdi;
         tandem_odi_alarm_o <= next_tc;
         tandem_rdi_alarm_o <= next_tc;
      end
   end

   // ----------------------------------------
   // V1 multiframe reference
   // ----------------------------------------
   function automatic logic h4_phase_hit(input logic [7:0] b);
      h4_phase_hit = (b[1:0] == damp_pkg::H4_V1_PHASE);
   endfunction

   logic h4_v1;
   logic next_drop_a;
   logic next_drop_b;
   logic next_add;

   always_comb begin
      // Detector gated off while composite V1 is in use
      h4_v1 = !v1_sel && h4_valid_i && h4_phase_hit(h4_byte_i);
      if (v1_sel) begin
         next_drop_a = composite_frame_sync_a_i;
         next_drop_b = composite_frame_sync_b_i;
      end else begin
         next_drop_a = h4_v1;
         next_drop_b = h4_v1;
      end
      case ({v1_sel, v1_ref})
         2'h0: next_add = composite_frame_sync_add_i;
         2'h1: next_add = h4_v1;
         2'h2: next_add = composite_frame_sync_add_i;
         default: next_add = composite_frame_sync_a_i;
      endcase
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         drop_v1_a_o <= 1'b0;
         drop_v1_b_o <= 1'b0;
         add_v1_o <= 1'b0;
      end else begin
         drop_v1_a_o <= next_drop_a;
         drop_v1_b_o <= next_drop_b;
         add_v1_o <= next_add;
      end
   end

   // ----------------------------------------
   // Drop indication delay and NPI fill
   // ----------------------------------------
   logic [1:0] ind_stage;
   logic [1:0] next_stage;
   logic [1:0] next_ind;
   logic next_npi_oe;

   always_comb begin
      next_stage = {drop_indication_b_i, drop_indication_a_i};
      next_ind = ind_delay ? ind_stage : next_stage;
      // Unused bytes left undriven unless forced to zero
      next_npi_oe = npi_zero && npi_enable_i && npi_unused_slot_i;
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ind_stage <= '0;
         drop_indication_a_o <= 1'b0;
         drop_indication_b_o <= 1'b0;
         npi_oe_o <= 1'b0;
         npi_data_o <= damp_pkg::NPI_FILL;
      end else begin
         ind_stage <= next_stage;
         drop_indication_a_o <= next_ind[0];
         drop_indication_b_o <= next_ind[1];
         npi_oe_o <= next_npi_oe;
         npi_data_o <= damp_pkg::NPI_FILL;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence s_ais_seen;
      ais_en && (ptr_ais_a_i || e1_ais_b_i);
   endsequence
   sequence s_uneq_seen;
      uneq_en && unequipped_b_i;
   endsequence

   a_ais_line_forced: assert property (s_ais_seen |=> rx_line_ais_o)
      else $error("AIS did not force line AIS");
   a_ais_rdi_auto: assert property (s_ais_seen ##0 rdi_auto |=>
      tx_rdi_o == {PORTS{1'b1}})
      else $error("AIS did not raise RDI");
   a_rdi_quiet: assert property (!rdi_auto && !uneq_en |=>
      tx_rdi_o == $past(channel_rdi_control_i))
      else $error("RDI raised without cause");
   a_uneq_tandem: assert property (s_uneq_seen |=> rx_line_ais_o &&
      tandem_odi_alarm_o && tandem_rdi_alarm_o && (&tx_rdi_o))
      else $error("Unequipped consequents missing");
   a_drop_h4_used: assert property (!v1_sel |=>
      drop_v1_a_o == $past(h4_v1) && drop_v1_b_o == $past(h4_v1))
      else $error("Drop V1 not from H4");
   a_drop_cfs_used: assert property (v1_sel |=>
      drop_v1_b_o == $past(composite_frame_sync_b_i) && !$past(h4_v1))
      else $error("Drop V1 not from composite sync");
   a_add_own_cfs: assert property (!v1_ref |=>
      add_v1_o == $past(composite_frame_sync_add_i))
      else $error("Add V1 not from add composite sync");
   a_add_from_h4: assert property (!v1_sel && v1_ref |=>
      add_v1_o == $past(h4_v1))
      else $error("Add V1 not from H4 detector");
   a_add_drop_cfs: assert property (v1_sel && v1_ref |=>
      add_v1_o == $past(composite_frame_sync_a_i))
      else $error("Add V1 not from drop composite sync");
   a_ind_two_clk: assert property (ind_delay ##1 ind_delay |->
      drop_indication_a_o == $past(drop_indication_a_i, 2))
      else $error("Drop indication delay wrong");
   a_ind_one_clk: assert property (!ind_delay |=>
      drop_indication_b_o == $past(drop_indication_b_i))
      else $error("Drop indication not one clock");
   a_npi_drive: assert property (npi_oe_o |-> npi_data_o == damp_pkg::NPI_FILL
      && $past(npi_zero && npi_enable_i && npi_unused_slot_i))
      else $error("NPI fill driven wrongly");
endmodule // damp_top

// ==== tb/damp_bus_model.sv ====
// Telecom bus timing source standing at the far side of the block
`timescale 1ns/10ps
module damp_bus_model (
   input wire logic clock_i,
   input wire logic [3:0] fire_i,
   input wire logic [7:0] h4_val_i,
   output logic sync_a_o,
   output logic sync_b_o,
   output logic sync_add_o,
   output logic h4_valid_o,
   output logic [7:0] h4_byte_o
);
   logic [7:0] last_h4 = 8'h00;
   // ----------------------------------------
   // Pulses follow the bench request
   // ----------------------------------------
   assign sync_a_o = fire_i[0];
   assign sync_b_o = fire_i[1];
   assign sync_add_o = fire_i[2];
   assign h4_valid_o = fire_i[3];
   // Outside its slot the byte lane holds nothing useful, so show junk
   assign h4_byte_o = fire_i[3] ? h4_val_i : ~last_h4;
   always @(posedge clock_i) begin
      if (h4_valid_o) begin
         last_h4 <= h4_byte_o;
      end
   end
endmodule // damp_bus_model

// ==== tb/drop_alarm_multiframe_provisioning_bench.sv ====
// Self-checking bench for the provisioning register block
`timescale 1ns/10ps
module drop_alarm_multiframe_provisioning_bench;
   localparam logic [9:0] CTRL = damp_pkg::CTRL_OFFSET;
   logic clock_i, rst_i, up_wr, up_rd, npi_en, npi_slot, hit, ea, eb, ed;
   logic [9:0] up_addr;
   logic [7:0] up_wdata, up_rdata, h4_val, h4_byte, npi_data;
   logic [3:0] ais_in, chan_rdi, fire, tx_rdi;
   logic [1:0] uneq, ind_in;
   logic [31:0] obit_sw, obit_tx;
   logic s_a, s_b, s_add, h4_v, line_ais, odi, trdi, v1_a, v1_b, v1_add;
   logic ind_a, ind_b, npi_oe;
   int n_errors = 0;
   int samples_checked = 0;
   int m, s;
   // ----------------------------------------
   // Clock, partner and device
   // ----------------------------------------
   initial begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end
   damp_bus_model bus_u (.clock_i(clock_i), .fire_i(fire), .h4_val_i(h4_val),
      .sync_a_o(s_a), .sync_b_o(s_b), .sync_add_o(s_add),
      .h4_valid_o(h4_v), .h4_byte_o(h4_byte));
   damp_top dut_u (.clock_i(clock_i), .rst_i(rst_i), .up_addr_i(up_addr),
      .up_wdata_i(up_wdata), .up_wr_i(up_wr), .up_rd_i(up_rd),
      .up_rdata_o(up_rdata), .ptr_ais_a_i(ais_in[0]),
      .ptr_ais_b_i(ais_in[1]), .e1_ais_a_i(ais_in[2]),
      .e1_ais_b_i(ais_in[3]), .unequipped_a_i(uneq[0]),
      .unequipped_b_i(uneq[1]), .channel_rdi_control_i(chan_rdi),
      .rx_line_ais_o(line_ais), .tx_rdi_o(tx_rdi),
      .tandem_odi_alarm_o(odi), .tandem_rdi_alarm_o(trdi),
      .composite_frame_sync_a_i(s_a), .composite_frame_sync_b_i(s_b),
      .composite_frame_sync_add_i(s_add), .h4_valid_i(h4_v),
      .h4_byte_i(h4_byte), .drop_v1_a_o(v1_a), .drop_v1_b_o(v1_b),
      .add_v1_o(v1_add), .drop_indication_a_i(ind_in[0]),
      .drop_indication_b_i(ind_in[1]), .drop_indication_a_o(ind_a),
      .drop_indication_b_o(ind_b), .npi_enable_i(npi_en),
      .npi_unused_slot_i(npi_slot), .npi_data_o(npi_data),
      .npi_oe_o(npi_oe), .obit_sw_i(obit_sw), .obit_tx_o(obit_tx));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      up_addr = a;
      up_wdata = d;
      up_wr = 1'b1;
      @(negedge clock_i);
      up_wr = 1'b0;
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      up_addr = a;
      up_rd = 1'b1;
      @(negedge clock_i);
      up_rd = 1'b0;
      chk({24'h0, up_rdata}, {24'h0, e});
   endtask
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Whole run needs well under a thousand cycles
   initial begin
      #(100 * 20000);
      n_errors++;
      close_out();
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      rst_i = 1'b1;
      {up_wr, up_rd, npi_en, npi_slot} = 4'h0;
      {up_addr, up_wdata, h4_val} = 26'h0;
      {ais_in, chan_rdi, fire, uneq, ind_in} = 16'h0;
      obit_sw = 32'h1234_5678;
      repeat (12) @(negedge clock_i);
      rst_i = 1'b0;
      @(negedge clock_i);
      rd(CTRL, damp_pkg::CTRL_RESET);
      wr(10'h014, 8'hff);
      rd(10'h014, damp_pkg::READ_UNMAPPED);
      // Let an edge pass so the read strobe is not re-raised at once
      @(negedge clock_i);
      rd(CTRL, 8'h00);
      for (m = 0; m < 3; m++) begin
         wr(CTRL, (m == 0) ? 8'ha5 : (m == 1) ? 8'h5a : 8'hff);
         rd(CTRL, (m == 0) ? 8'ha5 : (m == 1) ? 8'h5a : 8'hff);
      end
      // Pointer and E1 AIS with enable and RDI auto in all four mixes
      for (m = 0; m < 4; m++) begin
         wr(CTRL, {m[1], 2'h0, m[0], 4'h0});
         for (s = 0; s < 4; s++) begin
            ais_in = 4'h1 << s;
            @(negedge clock_i);
            ais_in = 4'h0;
            chk(line_ais, m[1]);
            chk(tx_rdi, (m == 3) ? 4'hf : 4'h0);
         end
      end
      for (m = 0; m < 2; m++) begin
         wr(CTRL, {6'h0, m[0], 1'b0});
         for (s = 0; s < 2; s++) begin
            uneq = 2'h1 << s;
            @(negedge clock_i);
            uneq = 2'h0;
            chk({line_ais, tx_rdi, odi, trdi}, {7{m[0]}});
         end
      end
      chan_rdi = 4'h5;
      @(negedge clock_i);
      chan_rdi = 4'h0;
      chk(tx_rdi, 4'h5);
      // Every select and reference mix against every V1 source
      for (m = 0; m < 4; m++) begin
         wr(CTRL, {1'b0, m[1], m[0], 5'h0});
         for (s = 0; s < 4; s++) begin
            fire = 4'h1 << s;
            h4_val = 8'h04;
            @(negedge clock_i);
            fire = 4'h0;
            hit = (s == 3) && !m[1];
            ea = m[1] ? (s == 0) : hit;
            eb = m[1] ? (s == 1) : hit;
            ed = m[0] ? ea : (s == 2);
            chk({v1_a, v1_b, v1_add}, {ea, eb, ed});
         end
      end
      wr(CTRL, 8'h00);
      fire = 4'h8;
      h4_val = 8'h05;
      @(negedge clock_i);
      fire = 4'h0;
      chk({v1_a, v1_b, v1_add}, 3'h0);
      for (m = 0; m < 2; m++) begin
         wr(CTRL, {5'h0, m[0], 2'h0});
         ind_in = 2'h3;
         @(negedge clock_i);
         ind_in = 2'h0;
         chk({ind_a, ind_b}, m[0] ? 2'h0 : 2'h3);
         @(negedge clock_i);
         chk({ind_a, ind_b}, m[0] ? 2'h3 : 2'h0);
      end
      for (m = 0; m < 2; m++) begin
         wr(CTRL, {4'h0, m[0], 3'h0});
         npi_en = 1'b1;
         npi_slot = 1'b1;
         @(negedge clock_i);
         chk({npi_oe, npi_data}, {m[0], 8'h00});
         npi_slot = 1'b0;
         @(negedge clock_i);
         chk(npi_oe, 1'b0);
         // Unused slot without NPI enabled stays undriven
         {npi_en, npi_slot} = 2'h1;
         @(negedge clock_i);
         chk(npi_oe, 1'b0);
      end
      for (m = 0; m < 2; m++) begin
         wr(CTRL, {7'h0, m[0]});
         @(negedge clock_i);
         chk(obit_tx, m[0] ? 32'h0 : 32'h1234_5678);
      end
      // Reset in mid-run must clear the register again
      wr(CTRL, 8'hff);
      rst_i = 1'b1;
      @(negedge clock_i);
      rst_i = 1'b0;
      @(negedge clock_i);
      rd(CTRL, damp_pkg::CTRL_RESET);
      close_out();
   end
endmodule // drop_alarm_multiframe_provisioning_bench
